//--- rtl/gdsl_defs.vh
`ifndef GDSL_DEFS_VH
`define GDSL_DEFS_VH

// ************************************************************
// Register map
// ************************************************************
`define GDSL_ADDR_W        12
`define GDSL_OFF_DIR       12'h014
`define GDSL_OFF_DIRECTION_SET_ALIAS    12'h018
`define GDSL_OFF_DIRECTION_CLEAR_ALIAS    12'h01C
`define GDSL_OFF_LATCH     12'h020
`define GDSL_OFF_SENSE_LO  12'h030
`define GDSL_OFF_SENSE_HI  12'h034
`define GDSL_OFF_IRQ_STAT  12'h040
`define GDSL_OFF_IRQ_MASK  12'h044
`define GDSL_RST_WORD      32'h00000000

// ************************************************************
// Sense encodings
// ************************************************************
`define GDSL_SENSE_OFF     2'h0
`define GDSL_SENSE_HIGH    2'h2
`define GDSL_SENSE_LOW     2'h3

`endif

//--- rtl/gdsl_sense_cell.v
`include "gdsl_defs.vh"

// ************************************************************
// Per-pin sense detector
// ************************************************************
module gdsl_sense_cell (
  input  wire [1:0] i_sense,
  input  wire       i_pin,
  output wire       o_hit
);
  // Encoding 1 is undefined and treated as disabled.
  assign o_hit = ((i_sense == `GDSL_SENSE_HIGH) &&  i_pin) ||
                 ((i_sense == `GDSL_SENSE_LOW)  && !i_pin);
endmodule // gdsl_sense_cell

//--- rtl/gdsl_latch.v
`include "gdsl_defs.vh"

// ************************************************************
// Direction and sense-latch registers
// ************************************************************
module gdsl_latch #(
  parameter NPINS = 32
) (
  input  wire                    i_clk,
  input  wire                    i_sys_rst,
  input  wire [`GDSL_ADDR_W-1:0] i_addr,
  input  wire [31:0]             i_wdata,
  input  wire                    i_wr,
  input  wire                    i_rd,
  output wire [31:0]             o_rdata,
  input  wire [NPINS-1:0]        i_pins,
  output wire [NPINS-1:0]        o_dir,
  output wire [NPINS-1:0]        o_latch,
  output wire                    o_irq
);

  reg  [NPINS-1:0]   dir_q;
  reg  [NPINS-1:0]   dir_d;
  reg  [NPINS-1:0]   latch_q;
  reg  [NPINS-1:0]   latch_d;
  reg  [2*NPINS-1:0] sense_q;
  reg  [NPINS-1:0]   sense_lo_w;
  reg  [NPINS-1:0]   sense_hi_w;
  reg  [31:0]        rdata_q;
  reg  [31:0]        rdata_d;
  reg  [1:0]         stat_q;
  reg  [1:0]         stat_d;
  reg  [1:0]         mask_q;
  wire [NPINS-1:0]   hit;
  wire [NPINS-1:0]   new_hit;
  wire               wr_dir;
  wire               wr_set;
  wire               wr_clr;
  wire               wr_latch;
  wire               wr_slo;
  wire               wr_shi;
  wire               wr_stat;
  wire               wr_mask;
  integer            k;
  integer            j;

  assign wr_dir   = i_wr && (i_addr == `GDSL_OFF_DIR);
  assign wr_set   = i_wr && (i_addr == `GDSL_OFF_DIRECTION_SET_ALIAS);
  assign wr_clr   = i_wr && (i_addr == `GDSL_OFF_DIRECTION_CLEAR_ALIAS);
  assign wr_latch = i_wr && (i_addr == `GDSL_OFF_LATCH);
  assign wr_slo   = i_wr && (i_addr == `GDSL_OFF_SENSE_LO);
  assign wr_shi   = i_wr && (i_addr == `GDSL_OFF_SENSE_HI);
  assign wr_stat  = i_wr && (i_addr == `GDSL_OFF_IRQ_STAT);
  assign wr_mask  = i_wr && (i_addr == `GDSL_OFF_IRQ_MASK);

  // ************************************************************
  // Sense detection
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : g_pin
      gdsl_sense_cell u_cell (
        .i_sense (sense_q[2*g+1:2*g]),
        .i_pin   (i_pins[g]),
        .o_hit   (hit[g])
      );
    end
  endgenerate

  assign new_hit = hit & ~latch_q;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always @* begin
    dir_d = dir_q;
    if (wr_dir) begin
      dir_d = i_wdata[NPINS-1:0];
    end else if (wr_set) begin
      dir_d = dir_q | i_wdata[NPINS-1:0];
    end else if (wr_clr) begin
      dir_d = dir_q & ~i_wdata[NPINS-1:0];
    end
    // A new hit in the cycle of a clearing write wins over the clear.
    latch_d = latch_q;
    if (wr_latch) begin
      latch_d = latch_q & ~i_wdata[NPINS-1:0];
    end
    latch_d = latch_d | hit;
    // Status bit 0: a pin latched; bit 1: a pin's direction changed.
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~i_wdata[1:0];
    end
    if (|new_hit) begin
      stat_d[0] = 1'b1;
    end
    if (dir_d != dir_q) begin
      stat_d[1] = 1'b1;
    end
  end

  always @* begin
    sense_lo_w = {NPINS{1'b0}};
    sense_hi_w = {NPINS{1'b0}};
    for (k = 0; k < NPINS; k = k + 1) begin
      sense_lo_w[k] = sense_q[2*k];
      sense_hi_w[k] = sense_q[2*k+1];
    end
  end

  always @* begin
    rdata_d = `GDSL_RST_WORD;
    case (i_addr)
      `GDSL_OFF_DIR,
      `GDSL_OFF_DIRECTION_SET_ALIAS,
      `GDSL_OFF_DIRECTION_CLEAR_ALIAS:   rdata_d[NPINS-1:0] = dir_q;
      `GDSL_OFF_LATCH:    rdata_d[NPINS-1:0] = latch_q;
      `GDSL_OFF_SENSE_LO: rdata_d[NPINS-1:0] = sense_lo_w;
      `GDSL_OFF_SENSE_HI: rdata_d[NPINS-1:0] = sense_hi_w;
      `GDSL_OFF_IRQ_STAT: rdata_d[1:0] = stat_q;
      `GDSL_OFF_IRQ_MASK: rdata_d[1:0] = mask_q;
      default:            rdata_d = `GDSL_RST_WORD;
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Retention is a property of the power domain: these flops are cleared by the system reset,
  // by clearing writes (latch_q, stat_q) or, for rdata_q, by a cycle without i_rd, never by a low-power entry.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      dir_q   <= {NPINS{1'b0}};
      latch_q <= {NPINS{1'b0}};
      sense_q <= {2*NPINS{1'b0}};
      rdata_q <= `GDSL_RST_WORD;
      stat_q  <= 2'h0;
      mask_q  <= 2'h0;
    end else begin
      dir_q   <= dir_d;
      latch_q <= latch_d;
      stat_q  <= stat_d;
      if (i_rd) begin
        rdata_q <= rdata_d;
      end else begin
        rdata_q <= `GDSL_RST_WORD;
      end
      if (wr_mask) begin
        mask_q <= i_wdata[1:0];
      end
      // A loop index of its own keeps this process from sharing a driver with the read-back logic.
      for (j = 0; j < NPINS; j = j + 1) begin
        if (wr_slo) begin
          sense_q[2*j] <= i_wdata[j];
        end
        if (wr_shi) begin
          sense_q[2*j+1] <= i_wdata[j];
        end
      end
    end
  end

  assign o_rdata = rdata_q;
  assign o_dir   = dir_q;
  assign o_latch = latch_q;
  assign o_irq   = |(stat_q & mask_q);

endmodule // gdsl_latch

//--- tb/gdsl_latch_asserts.sv
module gdsl_latch_chk #(
  parameter NPINS = 32
) (
  input wire logic             i_clk,
  input wire logic             i_sys_rst,
  input wire logic [11:0]      i_addr,
  input wire logic [31:0]      i_wdata,
  input wire logic             i_wr,
  input wire logic             i_rd,
  input wire logic [31:0]      o_rdata,
  input wire logic [NPINS-1:0] i_pins,
  input wire logic [NPINS-1:0] o_dir,
  input wire logic [NPINS-1:0] o_latch,
  input wire logic             o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Register checks
  // ****
  wire [31:0] clr_m = (i_wr && i_addr == 12'h020) ? i_wdata : 32'h0;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_wr; i_wr && i_addr == 12'h014 |=> o_dir == $past(i_wdata); endproperty
  a_wr: assert property (p_wr) else $error("dir write");
  property p_set; i_wr && i_addr == 12'h018 |=> o_dir == ($past(o_dir) | $past(i_wdata)); endproperty
  a_set: assert property (p_set) else $error("dir set");
  property p_clr; i_wr && i_addr == 12'h01C |=> o_dir == ($past(o_dir) & ~$past(i_wdata)); endproperty
  a_clr: assert property (p_clr) else $error("dir clear");
  property p_ali; i_rd && (i_addr == 12'h018 || i_addr == 12'h01C) |=> o_rdata == $past(o_dir); endproperty
  a_ali: assert property (p_ali) else $error("alias read");
  property p_drd; i_rd && i_addr == 12'h014 |=> o_rdata == $past(o_dir); endproperty
  a_drd: assert property (p_drd) else $error("dir read");
  property p_lrd; i_rd && i_addr == 12'h020 |=> o_rdata == $past(o_latch); endproperty
  a_lrd: assert property (p_lrd) else $error("latch read");
  property p_hold; !i_wr |=> $stable(o_dir); endproperty
  a_hold: assert property (p_hold) else $error("dir lost");
  property p_keep; 1 |=> ($past(o_latch) & ~$past(clr_m) & ~o_latch) == 32'h0; endproperty
  a_keep: assert property (p_keep) else $error("latch lost");
  cover property (i_wr && i_addr == 12'h018);
  cover property (|o_latch);
  cover property (o_irq);
endmodule // gdsl_latch_chk

bind gdsl_latch gdsl_latch_chk #(.NPINS(NPINS)) chk_u (
  .i_clk     (i_clk),
  .i_sys_rst (i_sys_rst),
  .i_addr    (i_addr),
  .i_wdata   (i_wdata),
  .i_wr      (i_wr),
  .i_rd      (i_rd),
  .o_rdata   (o_rdata),
  .i_pins    (i_pins),
  .o_dir     (o_dir),
  .o_latch   (o_latch),
  .o_irq     (o_irq)
);

//--- tb/gdsl_pins.sv
module gdsl_pins (
  input  wire logic [31:0] i_lvl,
  input  wire logic [31:0] i_dir,
  output wire logic [31:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Output pins read low, since the model masks each level bit with the inverse of its direction bit.
  assign o_pins = i_lvl & ~i_dir;
endmodule // gdsl_pins

//--- tb/test_gdsl_latch.sv
module test_gdsl_latch;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, o_irq;
  logic [11:0] i_addr = 12'h0;
  logic [31:0] i_wdata = 32'h0, lvl = 32'h0, o_rdata, o_dir, o_latch, i_pins;
  int          bad_count, checks_done, cyc;
  bit   [31:0] dir, lat, lo, hi, r;
  // ****
  // Harness
  // ****
  gdsl_pins pins_u (.i_lvl(lvl), .i_dir(o_dir), .o_pins(i_pins));
  gdsl_latch dut_u (.*);
  initial forever #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cyc > 2000) begin
    bad_count++;
    summarize();
  end
  task automatic chk(input logic [31:0] got, input bit [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input bit [11:0] a, input bit [31:0] d);
    @(posedge i_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
  endtask
  task automatic rd(input bit [11:0] a, input bit [31:0] e);
    @(posedge i_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    #1 chk(o_rdata, e);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    r = $urandom(32'h44c3);
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 0;
    chk(o_dir, 0);
    chk(o_latch, 0);
    dir = $urandom | 1;
    wr(12'h018, dir);
    rd(12'h040, 2);
    chk(o_irq, 0);
    wr(12'h044, 2);
    #1 chk(o_irq, 1);
    wr(12'h040, 2);
    #1 chk(o_irq, 0);
    $display("irq test done");
    for (int k = 0; k < 8; k++) begin
      r = $urandom;
      wr(12'h014, r);
      dir = r;
      r = $urandom;
      wr(12'h018, r);
      dir |= r;
      rd(12'h01C, dir);
      r = $urandom;
      wr(12'h01C, r);
      dir &= ~r;
      rd(12'h018, dir);
      rd(12'h014, dir);
      chk(o_dir, dir);
    end
    rd(12'h100, 0);
    $display("direction test done");
    wr(12'h014, 0);
    wr(12'h040, 3);
    lo = $urandom;
    hi = $urandom;
    lvl <= $urandom;
    wr(12'h030, lo);
    wr(12'h034, hi);
    lat = hi & (lo ^ lvl);
    rd(12'h020, lat);
    chk(o_latch, lat);
    rd(12'h040, {31'h0, lat != 0});
    wr(12'h044, 1);
    #1 chk(o_irq, {31'h0, lat != 0});
    wr(12'h034, 0);
    r = $urandom;
    wr(12'h020, r);
    rd(12'h020, lat & ~r);
    wr(12'h020, 32'hFFFFFFFF);
    rd(12'h020, 0);
    $display("latch test done");
    summarize();
  end
endmodule // test_gdsl_latch
